// >>> hw/uart_channel_map.vh
// Offsets, field positions, reset values and key values for one serial channel window.
// Assumes inclusion by the channel decode modules and the flow-character store only.
`ifndef UART_CHANNEL_MAP_VH
`define UART_CHANNEL_MAP_VH

`define OFS_DATA 3'h0
`define OFS_INT_EN 3'h1
`define OFS_INT_SRC 3'h2
`define OFS_LINE_FMT 3'h3
`define OFS_MODEM_CTL 3'h4
`define OFS_LINE_COND 3'h5
`define OFS_MODEM_COND 3'h6
`define OFS_SCRATCH 3'h7
`define OFS_ENH_FEAT 3'h2
`define OFS_XON1 3'h4
`define OFS_XON2 3'h5
`define OFS_XOFF1 3'h6
`define OFS_XOFF2 3'h7
`define OFS_ASR 3'h1
`define OFS_RFL 3'h3
`define OFS_TFL 3'h4
`define OFS_IDX_WIN 3'h5

`define FMT_DIV_SEL_BIT 7
`define ADD_EXT_BIT 7
`define ADD_IDX_BIT 6
`define FMT_UNLOCK_KEY 8'hBF
`define IDX_ADD_CTL 8'h00

`define FMT_RESET 8'h00
`define INT_EN_RESET 8'h00
`define MODEM_CTL_RESET 8'h00
`define SCRATCH_RESET 8'h00
`define DIV_RESET 8'h00
`define ENH_RESET 8'h00
`define FLOW_RESET 8'h00
`define ADD_CTL_RESET 8'h00

`define SEL_NONE 4'h0
`define SEL_DATA 4'h1
`define SEL_DIVL 4'h2
`define SEL_DIVH 4'h3
`define SEL_INT_EN 4'h4
`define SEL_FIFO 4'h5
`define SEL_FMT 4'h6
`define SEL_MODEM 4'h7
`define SEL_LINE_ST 4'h8
`define SEL_MODEM_ST 4'h9
`define SEL_SCRATCH 4'hA
`define SEL_ENH 4'hB
`define SEL_FLOW 4'hC
`define SEL_ASR 4'hD
`define SEL_LVL 4'hE
`define SEL_IDX 4'hF

`endif

// >>> hw/flow_char_store.v
// Four-byte store for the flow-control characters, registered read data.
// Assumes one write port and one read port sharing the channel clock.
`timescale 1ns/1ps
module flow_char_store (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire wr_en,
    input wire [1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [1:0] rd_addr,
    output reg [7:0] rd_data_q
);
`include "uart_channel_map.vh"

reg [7:0] mem_q [0:3];
genvar gi;

generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_word
        always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                mem_q[gi] <= `FLOW_RESET;
            end else if (clk_en && wr_en && wr_addr == gi) begin
                mem_q[gi] <= wr_data;
            end
        end
    end
endgenerate

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        rd_data_q <= `FLOW_RESET;
    end else if (clk_en) begin
        rd_data_q <= mem_q[rd_addr];
    end
end

endmodule // flow_char_store

// >>> hw/uart_channel_regs.v
// Register window decode and standard register set of one serial channel.
// Assumes host strobes synchronous to clock, one access per strobe pulse;
// read data are registered and valid the cycle after the read strobe, two cycles after it for flow characters.
`timescale 1ns/1ps
`include "uart_channel_map.vh"

// Notes on behaviour
// - The channel shows its registers in an eight-byte window selected by line and extra control.
// - With line-control bit 7 set, offsets 0 and 1 reach the low and high divisor bytes.
// - The line-control value gives the character format of transmitter and receiver.
// - Writing 0xBF to line-control unlocks the enhanced register set.
// - The unlock write sets only bit 7 and keeps bits 6 to 0 as they were.
// - Additional-control bit 7 maps the extended channel registers into the window.
// - Additional-control bit 6 makes the indexed register set readable.
// - At offset 0 without divisor select a write loads transmit data and a read gives receive data.
// - Offset 7 is a read-write scratch byte that also holds the indexed register index.
// - Transmit, receive and interrupt-enable registers are reached only while bit 7 is clear.
// - FIFO, interrupt, modem and line status and scratch need the last line-control write not to be the key.
// - Enhanced feature and four flow characters are reached only while the key is held.
// - Offset 5 writes the indexed register chosen by the scratch index, and reads it while additional-control bit 6 is set.
module uart_channel_regs (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire [2:0] addr,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] wr_data,
    input wire [7:0] rx_data,
    input wire [7:0] isr_value,
    input wire [7:0] lsr_value,
    input wire [7:0] msr_value,
    input wire [7:0] asr_value,
    input wire [7:0] rx_level,
    input wire [7:0] tx_level,
    input wire [7:0] idx_rd_value,
    output reg [7:0] rd_data_q,
    output reg [7:0] tx_data_q,
    output reg tx_load_q,
    output reg rx_pop_q,
    output reg [7:0] fifo_ctrl_q,
    output reg fifo_wr_q,
    output reg [7:0] asr_wr_q,
    output reg asr_wr_stb_q,
    output reg [7:0] idx_wr_q,
    output reg idx_wr_stb_q,
    output reg [7:0] line_format_q,
    output reg [15:0] baud_divisor_q,
    output reg [7:0] interrupt_enable_q,
    output reg [7:0] modem_line_control_q,
    output reg [7:0] enhanced_feature_q,
    output reg [7:0] scratch_and_index_q,
    output reg [7:0] additional_control_q
);

// ****************************************************************
// Decode
// ****************************************************************
reg key_q;
wire [3:0] wr_sel;
wire [3:0] rd_sel;
wire [7:0] flow_rd;
reg flow_rd_q;
reg [7:0] rd_mux;

// Key first, then divisor select, then extended selects
function [3:0] decode;
    input [2:0] ofs;
    input is_rd;
    input key;
    input dlab;
    input ext;
    input idx;
    begin
        decode = `SEL_NONE;
        if (key) begin
            case (ofs)
                3'h0: decode = `SEL_DIVL;
                3'h1: decode = `SEL_DIVH;
                `OFS_ENH_FEAT: decode = `SEL_ENH;
                `OFS_LINE_FMT: decode = `SEL_FMT;
                3'h4, 3'h5, 3'h6, 3'h7: decode = `SEL_FLOW;
                default: decode = `SEL_NONE;
            endcase
        end else begin
            case (ofs)
                `OFS_DATA: decode = dlab ? `SEL_DIVL : `SEL_DATA;
                `OFS_INT_EN: begin
                    if (dlab) begin
                        decode = `SEL_DIVH;
                    end else if (ext) begin
                        decode = `SEL_ASR;
                    end else begin
                        decode = `SEL_INT_EN;
                    end
                end
                `OFS_INT_SRC: decode = `SEL_FIFO;
                `OFS_LINE_FMT: decode = (ext && is_rd) ? `SEL_LVL : `SEL_FMT;
                `OFS_MODEM_CTL: decode = (ext && is_rd) ? `SEL_LVL : `SEL_MODEM;
                `OFS_LINE_COND: begin
                    if (!is_rd) begin
                        decode = `SEL_IDX;
                    end else if (idx) begin
                        decode = `SEL_IDX;
                    end else begin
                        decode = `SEL_LINE_ST;
                    end
                end
                `OFS_MODEM_COND: decode = `SEL_MODEM_ST;
                `OFS_SCRATCH: decode = `SEL_SCRATCH;
                default: decode = `SEL_NONE;
            endcase
        end
    end
endfunction

assign wr_sel = decode(addr, 1'b0, key_q, line_format_q[`FMT_DIV_SEL_BIT],
    additional_control_q[`ADD_EXT_BIT], additional_control_q[`ADD_IDX_BIT]);
assign rd_sel = decode(addr, 1'b1, key_q, line_format_q[`FMT_DIV_SEL_BIT],
    additional_control_q[`ADD_EXT_BIT], additional_control_q[`ADD_IDX_BIT]);

// ****************************************************************
// Flow characters
// ****************************************************************
flow_char_store u_flow (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .wr_en(wr_stb && wr_sel == `SEL_FLOW),
    .wr_addr(addr[1:0]),
    .wr_data(wr_data),
    .rd_addr(addr[1:0]),
    .rd_data_q(flow_rd)
);

// ****************************************************************
// Writable registers
// ****************************************************************
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        key_q <= 1'b0;
        line_format_q <= `FMT_RESET;
        baud_divisor_q <= {`DIV_RESET, `DIV_RESET};
        interrupt_enable_q <= `INT_EN_RESET;
        modem_line_control_q <= `MODEM_CTL_RESET;
        enhanced_feature_q <= `ENH_RESET;
        scratch_and_index_q <= `SCRATCH_RESET;
        additional_control_q <= `ADD_CTL_RESET;
        tx_data_q <= 8'h00;
        tx_load_q <= 1'b0;
        fifo_ctrl_q <= 8'h00;
        fifo_wr_q <= 1'b0;
        asr_wr_q <= 8'h00;
        asr_wr_stb_q <= 1'b0;
        idx_wr_q <= 8'h00;
        idx_wr_stb_q <= 1'b0;
    end else if (clk_en) begin
        tx_load_q <= 1'b0;
        fifo_wr_q <= 1'b0;
        asr_wr_stb_q <= 1'b0;
        idx_wr_stb_q <= 1'b0;
        if (wr_stb) begin
            case (wr_sel)
                `SEL_FMT: begin
                    if (wr_data == `FMT_UNLOCK_KEY) begin
                        key_q <= 1'b1;
                        line_format_q[`FMT_DIV_SEL_BIT] <= 1'b1;
                    end else begin
                        key_q <= 1'b0;
                        line_format_q <= wr_data;
                    end
                end
                `SEL_DIVL: baud_divisor_q[7:0] <= wr_data;
                `SEL_DIVH: baud_divisor_q[15:8] <= wr_data;
                `SEL_DATA: begin
                    tx_data_q <= wr_data;
                    tx_load_q <= 1'b1;
                end
                `SEL_INT_EN: interrupt_enable_q <= wr_data;
                `SEL_FIFO: begin
                    fifo_ctrl_q <= wr_data;
                    fifo_wr_q <= 1'b1;
                end
                `SEL_MODEM: modem_line_control_q <= wr_data;
                `SEL_SCRATCH: scratch_and_index_q <= wr_data;
                `SEL_ENH: enhanced_feature_q <= wr_data;
                `SEL_ASR: begin
                    asr_wr_q <= wr_data;
                    asr_wr_stb_q <= 1'b1;
                end
                `SEL_IDX: begin
                    if (scratch_and_index_q == `IDX_ADD_CTL) begin
                        additional_control_q <= wr_data;
                    end else begin
                        idx_wr_q <= wr_data;
                        idx_wr_stb_q <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end
end

// ****************************************************************
// Read path
// ****************************************************************
always @* begin
    case (rd_sel)
        `SEL_DATA: rd_mux = rx_data;
        `SEL_DIVL: rd_mux = baud_divisor_q[7:0];
        `SEL_DIVH: rd_mux = baud_divisor_q[15:8];
        `SEL_INT_EN: rd_mux = interrupt_enable_q;
        `SEL_FIFO: rd_mux = isr_value;
        `SEL_FMT: rd_mux = line_format_q;
        `SEL_MODEM: rd_mux = modem_line_control_q;
        `SEL_LINE_ST: rd_mux = lsr_value;
        `SEL_MODEM_ST: rd_mux = msr_value;
        `SEL_SCRATCH: rd_mux = scratch_and_index_q;
        `SEL_ENH: rd_mux = enhanced_feature_q;
        `SEL_ASR: rd_mux = asr_value;
        `SEL_LVL: rd_mux = (addr == `OFS_RFL) ? rx_level : tx_level;
        `SEL_IDX: rd_mux = (scratch_and_index_q == `IDX_ADD_CTL) ?
            additional_control_q : idx_rd_value;
        default: rd_mux = 8'h00;
    endcase
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        rd_data_q <= 8'h00;
        rx_pop_q <= 1'b0;
    end else if (clk_en) begin
        rx_pop_q <= rd_stb && rd_sel == `SEL_DATA;
        if (rd_stb) begin
            rd_data_q <= (rd_sel == `SEL_FLOW) ? 8'h00 : rd_mux;
        end else if (flow_rd_q) begin
            rd_data_q <= flow_rd;
        end
    end
end

// Flow store read data arrive one cycle later
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        flow_rd_q <= 1'b0;
    end else if (clk_en) begin
        flow_rd_q <= rd_stb && rd_sel == `SEL_FLOW;
    end
end

endmodule // uart_channel_regs

// >>> bench/chan_far_model.sv
// Far-side model: receive bytes and status values for one channel.
// Assumes the channel pops the receive byte with a one-cycle pulse.
`timescale 1ns/1ps
module chan_far_model (
    input wire clock,
    input wire rstn,
    input wire rx_pop,
    output reg [7:0] rx_data,
    output wire [7:0] interrupt_source,
    output wire [7:0] line_condition,
    output wire [7:0] modem_line_condition,
    output wire [7:0] asr,
    output wire [7:0] rxl,
    output wire [7:0] txl,
    output wire [7:0] idx
);
    // Next byte appears once the current one is taken
    always @(posedge clock or negedge rstn) begin
        if (!rstn)
            rx_data <= 8'hA7;
        else if (rx_pop)
            rx_data <= rx_data + 8'h3D;
    end
    assign interrupt_source = rx_data ^ 8'h11;
    assign line_condition = rx_data ^ 8'h22;
    assign modem_line_condition = rx_data ^ 8'h44;
    assign asr = rx_data ^ 8'h88;
    assign rxl = rx_data ^ 8'h5C;
    assign txl = rx_data ^ 8'hC5;
    assign idx = ~rx_data;
endmodule // chan_far_model

// >>> bench/uart_channel_regs_props.sv
// Port-level checks of the channel register decode.
// Assumes binding to uart_channel_regs.
`timescale 1ns/1ps
module uart_channel_regs_props (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire [2:0] addr,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] wr_data,
    input wire [7:0] rx_data,
    input wire [7:0] rd_data_q,
    input wire [7:0] tx_data_q,
    input wire tx_load_q,
    input wire rx_pop_q,
    input wire [7:0] fifo_ctrl_q,
    input wire fifo_wr_q,
    input wire [7:0] line_format_q,
    input wire [15:0] baud_divisor_q,
    input wire [7:0] enhanced_feature_q,
    input wire [7:0] scratch_and_index_q
);
    wire w = clk_en & wr_stb;
    wire r = clk_en & rd_stb;
    wire dl = line_format_q[7];
    reg key_q;
    // Tracks whether the last line-control write was the key
    always @(posedge clock or negedge rstn) begin
        if (!rstn)
            key_q <= 1'b0;
        else if (w && addr == 3'h3)
            key_q <= (wr_data == 8'hBF);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_tx_load: assert property (
        w && addr == 3'h0 && !dl |=> tx_load_q && tx_data_q == $past(wr_data))
        else $error("tx load wrong");
    a_div_low: assert property (
        w && addr == 3'h0 && dl |=> !tx_load_q && baud_divisor_q[7:0] == $past(wr_data))
        else $error("divisor low wrong");
    a_div_high: assert property (
        w && addr == 3'h1 && dl |=> baud_divisor_q[15:8] == $past(wr_data))
        else $error("divisor high wrong");
    a_rx_read: assert property (
        r && addr == 3'h0 && !dl |=> rx_pop_q && rd_data_q == $past(rx_data))
        else $error("rx read wrong");
    a_unlock_keep: assert property (
        w && addr == 3'h3 && wr_data == 8'hBF |=>
        line_format_q == {1'b1, $past(line_format_q[6:0])})
        else $error("unlock changed format");
    a_plain_format: assert property (
        w && addr == 3'h3 && wr_data != 8'hBF |=> line_format_q == $past(wr_data))
        else $error("format write wrong");
    a_scratch_write: assert property (
        w && addr == 3'h7 && !key_q |=> scratch_and_index_q == $past(wr_data))
        else $error("scratch write wrong");
    a_key_guard: assert property (
        w && addr == 3'h7 && key_q |=> $stable(scratch_and_index_q))
        else $error("scratch reached in key mode");
    a_efr_write: assert property (
        w && addr == 3'h2 && key_q |=> !fifo_wr_q && enhanced_feature_q == $past(wr_data))
        else $error("enhanced write wrong");
    a_fifo_write: assert property (
        w && addr == 3'h2 && !key_q |=> fifo_wr_q && fifo_ctrl_q == $past(wr_data))
        else $error("fifo write wrong");
    a_freeze_hold: assert property (
        !clk_en |=> $stable(line_format_q) && $stable(scratch_and_index_q))
        else $error("state moved while frozen");
endmodule // uart_channel_regs_props
bind uart_channel_regs uart_channel_regs_props u_props (.*);

// >>> bench/testbench.sv
// Self-checking bench for the channel register decode.
// Assumes the far-side model supplies receive and status bytes.
`timescale 1ns/1ps
module testbench;
    logic clock = 0, rstn = 0, clk_en = 0, wr_stb = 0, rd_stb = 0, rd_seen = 0;
    logic [2:0] addr = 0;
    logic [7:0] wr_data = 0, rd_data_q, tx_data_q, lf, sc, ef, ac, iw, e;
    logic [7:0] rxd, isv, lsv, msv, asv, rxl, txl, idv;
    logic tx_load_q, rx_pop_q, iws;
    logic [15:0] bd;
    logic [31:0] lfsr = 32'h0468EB4E;
    logic [7:0] q[$];
    int mismatches = 0, checked = 0;
    chan_far_model u_far (.clock(clock), .rstn(rstn), .rx_pop(rx_pop_q), .rx_data(rxd),
        .interrupt_source(isv), .line_condition(lsv), .modem_line_condition(msv), .asr(asv), .rxl(rxl), .txl(txl), .idx(idv));
    uart_channel_regs u_dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .addr(addr),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rx_data(rxd),
        .isr_value(isv), .lsr_value(lsv), .msr_value(msv), .asr_value(asv),
        .rx_level(rxl), .tx_level(txl), .idx_rd_value(idv), .rd_data_q(rd_data_q),
        .tx_data_q(tx_data_q), .tx_load_q(tx_load_q), .rx_pop_q(rx_pop_q),
        .fifo_ctrl_q(), .fifo_wr_q(), .asr_wr_q(), .asr_wr_stb_q(), .idx_wr_q(iw),
        .idx_wr_stb_q(iws), .line_format_q(lf), .baud_divisor_q(bd),
        .interrupt_enable_q(), .modem_line_control_q(), .enhanced_feature_q(ef),
        .scratch_and_index_q(sc), .additional_control_q(ac));
    initial forever #12.5 clock = ~clock;
    function automatic [31:0] nxt(input [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input [15:0] seen, input [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input rd, input [2:0] a, input [7:0] d);
        @(negedge clock);
        addr = a;
        wr_data = d;
        wr_stb = !rd;
        rd_stb = rd;
        @(negedge clock);
        wr_stb = 0;
        rd_stb = 0;
    endtask
    task automatic rd(input [2:0] a, input [7:0] x);
        q.push_back(x);
        acc(1, a, 8'h00);
    endtask
    task automatic end_sim;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Read data lands one cycle after the strobe is taken
    always @(posedge clock) begin
        if (rd_seen)
            check(rd_data_q, q.pop_front());
        rd_seen <= rd_stb & clk_en;
    end
    initial begin
        #50000;
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (5) @(negedge clock);
        rstn = 1;
        clk_en = 1;
        acc(0, 3, 8'h03);
        rd(3, 8'h03);
        acc(0, 3, 8'h83);
        acc(0, 0, 8'h12);
        check(tx_load_q, 0);
        acc(0, 1, 8'h34);
        check(bd, 16'h3412);
        rd(0, 8'h12);
        acc(0, 3, 8'h03);
        acc(0, 2, 8'h07);
        repeat (4) begin
            lfsr = nxt(lfsr);
            acc(0, 0, lfsr[7:0]);
            check({tx_load_q, tx_data_q}, {1'b1, lfsr[7:0]});
            e = rxd;
            rd(0, e);
            check(rx_pop_q, 1);
            acc(0, 7, lfsr[15:8]);
            rd(7, lfsr[15:8]);
            acc(0, 1, lfsr[23:16]);
            rd(1, lfsr[23:16]);
        end
        acc(0, 7, 8'h5A);
        acc(0, 3, 8'hBF);
        check(lf, 8'h83);
        acc(0, 2, 8'h66);
        check(ef, 8'h66);
        acc(0, 7, 8'hA5);
        check(sc, 8'h5A);
        rd(7, 8'h00);
        @(negedge clock);
        check(rd_data_q, 8'hA5);
        acc(0, 3, 8'h03);
        acc(0, 7, 8'h00);
        check(sc, 8'h00);
        acc(0, 5, 8'hC0);
        check(ac, 8'hC0);
        rd(3, rxl);
        acc(0, 7, 8'h01);
        acc(0, 5, 8'h77);
        check({iws, iw}, {1'b1, 8'h77});
        rd(5, idv);
        clk_en = 0;
        acc(0, 3, 8'h1F);
        clk_en = 1;
        check(lf, 8'h03);
        repeat (3) @(negedge clock);
        end_sim;
    end
endmodule // testbench
